// >>> conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

`include "conv_ctrl_map.svh"

// Contract
// - Sensor type from word bits 31..27
// - Decode five-bit code into sensor families
// - Go=1, finish=0 write starts a conversion
// - Channel field zero scans configured channels
// - Field is binary channel; 10111 sleeps
// - Storage variant uses field for storage
// - Completion pin low during conversion
// - Flags become 01, pin rises
// - Only status read allowed while converting
// - Sensor and companion measured together
// - Two or three 82 ms cycles
// - Results in four-byte slots from 0x010
module conv_ctrl #(
   parameter int CYCLE_CLKS = `MEAS_CYCLE_MS * (`CLK_HZ / 1000),
   parameter bit HAS_NVM = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Host register port
   input wire conv_ctrl_pkg::host_req_t host,
   output logic [7:0] rdata,
   // Measurement engine
   output conv_ctrl_pkg::meas_req_t meas,
   input wire logic [31:0] result_word,
   // Storage engine (storage variant only)
   output logic nvm_start,
   output logic [4:0] nvm_code,
   input wire logic nvm_done,
   // Pins and interrupt
   output logic done_pin,
   output logic sleep,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   conv_ctrl_pkg::conv_state_t state_r, state_nxt;
   logic [7:0] cmd_r;
   logic [4:0] type_r [1:`NUM_CH];
   logic [3:0] ch_r;
   logic scan_r;
   logic [31:0] cnt_r;
   logic [1:0] pass_r;
   logic [1:0] byte_r;
   logic [31:0] res_r;
   logic [`IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
   logic [2:0] rsel_r;
   logic [7:0] reg_rd_r;
   logic [7:0] mem_rdata;
   logic busy, host_ok_wr, cmd_wr, go_cmd, stat_wr, mask_wr;
   logic [4:0] sel;
   logic sel_chan, sel_rsv, cur_paired, cycle_end, last_pass;
   logic [4:0] cur_type;
   logic mem_we;
   logic [9:0] mem_addr, slot_addr;
   logic [7:0] mem_wdata;

   // Decode the five-bit sensor code into its family
   function automatic conv_ctrl_pkg::sensor_class_t classify(input logic [4:0] t);
      conv_ctrl_pkg::sensor_class_t c;
      c = conv_ctrl_pkg::SC_DISABLED;
      if (t >= 5'h01 && t <= 5'h08) c = conv_ctrl_pkg::SC_TC_STD;
      else if (t == 5'h09) c = conv_ctrl_pkg::SC_TC_CUSTOM;
      else if (t >= 5'h0a && t <= 5'h11) c = conv_ctrl_pkg::SC_RTD_STD;
      else if (t == 5'h12) c = conv_ctrl_pkg::SC_RTD_CUSTOM;
      else if (t >= 5'h13 && t <= 5'h19) c = conv_ctrl_pkg::SC_THERM_FIXED;
      else if (t == 5'h1a) c = conv_ctrl_pkg::SC_THERM_SH;
      else if (t == 5'h1b) c = conv_ctrl_pkg::SC_THERM_TABLE;
      else if (t == 5'h1c) c = conv_ctrl_pkg::SC_DIODE;
      else if (t == 5'h1d) c = conv_ctrl_pkg::SC_SENSE_RES;
      else if (t == 5'h1e) c = conv_ctrl_pkg::SC_DIRECT_ADC;
      else if (t == 5'h1f) c = conv_ctrl_pkg::SC_ANALOG_TS;
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Host decode
   // Lockout while busy
   assign busy = (state_r != conv_ctrl_pkg::ST_IDLE) && (state_r != conv_ctrl_pkg::ST_SLEEP);
   assign host_ok_wr = host.wr && !busy;
   assign cmd_wr = host_ok_wr && (host.addr == `CMD_ADDR);
   assign go_cmd = cmd_wr && host.wdata[`GO_BIT] && !host.wdata[`FINISH_BIT];
   assign stat_wr = host_ok_wr && (host.addr == `IRQ_STATUS_ADDR);
   assign mask_wr = host_ok_wr && (host.addr == `IRQ_MASK_ADDR);
   assign sel = host.wdata[`CHSEL_MSB:0];
   assign sel_chan = (sel >= 5'(`CH_FIRST)) && (sel <= 5'(`CH_LAST));
   assign sel_rsv = !sel_chan && (sel != `SEL_MULTI) && (sel != `SEL_SLEEP) && !HAS_NVM;

   ////////////////////////////////////////////////////////////////////////////
   // Sensor type shadow, one per channel, caught on assignment writes
   generate
      for (genvar k = 1; k <= `NUM_CH; k++) begin : g_type
         logic hit;
         assign hit = host_ok_wr && (host.addr == `ASSIGN_BASE + 10'((k - 1) * 4));
         // Top five bits, reset to disabled
         always_ff @(posedge clk_sys) begin
            if (reset) type_r[k] <= `TYPE_NONE;
            else if (hit) type_r[k] <= host.wdata[`TYPE_MSB:`TYPE_LSB];
         end
      end
   endgenerate

   // Current channel properties
   assign cur_type = (ch_r >= `CH_FIRST && ch_r <= `CH_LAST) ? type_r[ch_r] : `TYPE_NONE;
   // Sensors with a cold junction or sense resistor partner
   assign cur_paired = (cur_type >= 5'h01 && cur_type <= 5'h1b);
   // Three cycles for paired sensors, two otherwise
   assign cycle_end = (cnt_r == 32'(CYCLE_CLKS - 1));
   assign last_pass = (pass_r == (cur_paired ? `PASSES_PAIRED : `PASSES_SINGLE) - 2'd1);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         conv_ctrl_pkg::ST_IDLE, conv_ctrl_pkg::ST_SLEEP: begin
            if (go_cmd) begin
               if (sel == `SEL_SLEEP) state_nxt = conv_ctrl_pkg::ST_SLEEP;
               else if (sel_chan || sel == `SEL_MULTI) state_nxt = conv_ctrl_pkg::ST_NEXT;
               else if (HAS_NVM) state_nxt = conv_ctrl_pkg::ST_NVM;
               else state_nxt = conv_ctrl_pkg::ST_IDLE;
            end else if (host_ok_wr && state_r == conv_ctrl_pkg::ST_SLEEP) begin
               state_nxt = conv_ctrl_pkg::ST_IDLE;
            end
         end
         conv_ctrl_pkg::ST_NEXT: begin
            if (ch_r > `CH_LAST) state_nxt = conv_ctrl_pkg::ST_IDLE;
            else if (cur_type != `TYPE_NONE) state_nxt = conv_ctrl_pkg::ST_MEAS;
            else if (!scan_r) state_nxt = conv_ctrl_pkg::ST_IDLE;
         end
         conv_ctrl_pkg::ST_MEAS: begin
            if (cycle_end && last_pass) state_nxt = conv_ctrl_pkg::ST_STORE;
         end
         conv_ctrl_pkg::ST_STORE: begin
            if (byte_r == `STORE_LAST) begin
               state_nxt = scan_r ? conv_ctrl_pkg::ST_NEXT : conv_ctrl_pkg::ST_IDLE;
            end
         end
         conv_ctrl_pkg::ST_NVM: begin
            if (nvm_done) state_nxt = conv_ctrl_pkg::ST_IDLE;
         end
         default: state_nxt = conv_ctrl_pkg::ST_IDLE;
      endcase
   end

   // State and sequencing registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= conv_ctrl_pkg::ST_IDLE;
         ch_r <= 4'h0;
         scan_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (go_cmd) begin
            // Zero field scans from the first channel
            scan_r <= (sel == `SEL_MULTI);
            ch_r <= (sel == `SEL_MULTI) ? `CH_FIRST : sel[3:0];
         end else if (state_r == conv_ctrl_pkg::ST_NEXT && cur_type == `TYPE_NONE) begin
            ch_r <= ch_r + 4'h1;
         end else if (state_r == conv_ctrl_pkg::ST_STORE && byte_r == `STORE_LAST) begin
            ch_r <= ch_r + 4'h1;
         end
      end
   end

   // Cycle timer and pass count
   always_ff @(posedge clk_sys) begin
      if (reset || state_r != conv_ctrl_pkg::ST_MEAS) begin
         cnt_r <= 32'h0;
         pass_r <= 2'd0;
      end else if (cycle_end) begin
         cnt_r <= 32'h0;
         pass_r <= pass_r + 2'd1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // Result is caught at the end of the last pass
   always_ff @(posedge clk_sys) begin
      if (reset) res_r <= 32'h0;
      else if (state_r == conv_ctrl_pkg::ST_MEAS && cycle_end && last_pass) res_r <= result_word;
      if (reset || state_r != conv_ctrl_pkg::ST_STORE) byte_r <= 2'd0;
      else byte_r <= byte_r + 2'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command byte
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_r <= `CMD_RESET;
      end else if (cmd_wr) begin
         cmd_r <= host.wdata;
      // Go/finish flip to 01 at the end
      end else if (busy && state_nxt == conv_ctrl_pkg::ST_IDLE) begin
         cmd_r[`GO_BIT:`FINISH_BIT] <= `FLAGS_DONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to engines and pins
   // Sensor and partner requested in one go
   assign meas.start = (state_r == conv_ctrl_pkg::ST_NEXT) && (state_nxt == conv_ctrl_pkg::ST_MEAS);
   assign meas.channel = ch_r;
   assign meas.sensor = cur_type;
   assign meas.sclass = classify(cur_type);
   assign meas.paired = cur_paired;
   // Storage operations reuse the channel field
   assign nvm_start = (state_r == conv_ctrl_pkg::ST_NVM);
   assign nvm_code = cmd_r[`CHSEL_MSB:0];
   // Pin low for the whole conversion
   assign done_pin = !busy;
   assign sleep = (state_r == conv_ctrl_pkg::ST_SLEEP);

   ////////////////////////////////////////////////////////////////////////////
   // RAM port: host while idle, result store while busy, never both
   // Slot base 0x010, fault byte first
   assign slot_addr = `RESULT_BASE + {2'h0, 6'(ch_r - 4'h1), 2'b00};
   assign mem_we = (state_r == conv_ctrl_pkg::ST_STORE) || host_ok_wr;
   assign mem_addr = busy ? slot_addr + {8'h0, byte_r} : host.addr;
   assign mem_wdata = busy ? res_r[8'(31 - 8 * byte_r) -: 8] : host.wdata;

   conv_ram u_ram (
      .clk_sys(clk_sys),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: set wins over a write-one clear
   assign irq_set[`IRQ_DONE] = busy && state_nxt == conv_ctrl_pkg::ST_IDLE;
   assign irq_set[`IRQ_REFUSED] = (host.wr || (host.rd && host.addr != `CMD_ADDR)) && busy;
   assign irq_set[`IRQ_RESERVED] = go_cmd && sel_rsv;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(stat_wr ? host.wdata[`IRQ_W-1:0] : '0)) | irq_set;
         if (mask_wr) irq_mask_r <= host.wdata[`IRQ_W-1:0];
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // Read path: source picked on the strobe, data one cycle later
   // Locked reads answer zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rsel_r <= 3'd0;
         reg_rd_r <= 8'h00;
      end else if (host.rd) begin
         if (host.addr == `CMD_ADDR) begin
            rsel_r <= 3'd1;
            reg_rd_r <= cmd_r;
         end else if (busy) begin
            rsel_r <= 3'd1;
            reg_rd_r <= 8'h00;
         end else if (host.addr == `IRQ_STATUS_ADDR) begin
            rsel_r <= 3'd1;
            reg_rd_r <= {5'h0, irq_stat_r};
         end else if (host.addr == `IRQ_MASK_ADDR) begin
            rsel_r <= 3'd1;
            reg_rd_r <= {5'h0, irq_mask_r};
         end else begin
            rsel_r <= 3'd2;
         end
      end else begin
         rsel_r <= 3'd0;
      end
   end
   assign rdata = (rsel_r == 3'd2) ? mem_rdata : (rsel_r == 3'd1) ? reg_rd_r : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_pin_low_busy: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(done_pin) |-> $past(go_cmd))
      else $error("completion pin fell without a start");
   chk_start_follows: assert property (@(posedge clk_sys) disable iff (reset)
      (go_cmd && sel_chan) |=> state_r == conv_ctrl_pkg::ST_NEXT && !done_pin)
      else $error("start command not taken");
   chk_flags_done: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(done_pin) |-> cmd_r[`GO_BIT:`FINISH_BIT] == `FLAGS_DONE)
      else $error("flags not 01 at completion");
   chk_lock_read: assert property (@(posedge clk_sys) disable iff (reset)
      (busy && host.rd && host.addr != `CMD_ADDR) |=> rdata == 8'h00)
      else $error("locked read leaked data");
   chk_lock_write: assert property (@(posedge clk_sys) disable iff (reset)
      (busy && host.wr && state_nxt != conv_ctrl_pkg::ST_IDLE) |=> $stable(cmd_r))
      else $error("command changed while locked");
   chk_meas_length: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == conv_ctrl_pkg::ST_MEAS
      |-> pass_r < (cur_paired ? `PASSES_PAIRED : `PASSES_SINGLE))
      else $error("pass count out of range");
   chk_scan_start: assert property (@(posedge clk_sys) disable iff (reset)
      (go_cmd && sel == `SEL_MULTI) |=> scan_r && ch_r == `CH_FIRST)
      else $error("scan did not start at first channel");
   chk_store_four: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(state_r == conv_ctrl_pkg::ST_STORE) |-> mem_we [*4])
      else $error("result slot not written in four bytes");
   chk_type_shadow: assert property (@(posedge clk_sys) disable iff (reset)
      (host_ok_wr && host.addr == `ASSIGN_BASE)
      |=> type_r[1] == $past(host.wdata[`TYPE_MSB:`TYPE_LSB]))
      else $error("sensor type not captured");
   chk_sleep_cmd: assert property (@(posedge clk_sys) disable iff (reset)
      (go_cmd && sel == `SEL_SLEEP) |=> sleep && done_pin)
      else $error("sleep command not taken");
   chk_irq_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
      (irq_set != '0) |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
      else $error("status event lost to a clear");

endmodule

`default_nettype wire

// >>> conv_ctrl_map.svh
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH

// Byte address space of the device RAM
`define ADDR_W 10
`define CMD_ADDR 10'h000
`define RESULT_BASE 10'h010
`define ASSIGN_BASE 10'h200
`define SLOT_BYTES 10'h004
`define IRQ_STATUS_ADDR 10'h0f0
`define IRQ_MASK_ADDR 10'h0f4

// Command byte fields
`define GO_BIT 7
`define FINISH_BIT 6
`define CHSEL_MSB 4
`define CMD_RESET 8'h00
`define FLAGS_DONE 2'b01
`define SEL_MULTI 5'h00
`define SEL_SLEEP 5'h17
`define NUM_CH 10
`define CH_FIRST 4'h1
`define CH_LAST 4'ha

// Sensor type sits in the top five bits of the assignment word
`define TYPE_MSB 7
`define TYPE_LSB 3
`define TYPE_NONE 5'h00

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_RESERVED 2
`define IRQ_W 3

// Timing: one measurement cycle and the system clock
`define MEAS_CYCLE_MS 82
`define CLK_HZ 25000000
`define PASSES_PAIRED 2'd3
`define PASSES_SINGLE 2'd2
// Last byte of a four-byte result slot
`define STORE_LAST 2'd3

`endif

// >>> conv_ctrl_pkg.sv
`default_nettype none

package conv_ctrl_pkg;

   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_NEXT,
      ST_MEAS,
      ST_STORE,
      ST_NVM,
      ST_SLEEP
   } conv_state_t;

   // Sensor families decoded from the five-bit type code
   typedef enum logic [3:0] {
      SC_DISABLED,
      SC_TC_STD,
      SC_TC_CUSTOM,
      SC_RTD_STD,
      SC_RTD_CUSTOM,
      SC_THERM_FIXED,
      SC_THERM_SH,
      SC_THERM_TABLE,
      SC_DIODE,
      SC_SENSE_RES,
      SC_DIRECT_ADC,
      SC_ANALOG_TS
   } sensor_class_t;

   // Request to the analog measurement engine
   typedef struct packed {
      logic start;
      logic [3:0] channel;
      logic [4:0] sensor;
      sensor_class_t sclass;
      logic paired;
   } meas_req_t;

   // Host register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } host_req_t;

endpackage

`default_nettype wire

// >>> conv_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Byte-wide single-port RAM, read data registered
module conv_ram (
   // Clock
   input wire logic clk_sys,
   // Access port
   input wire logic we,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   logic [7:0] mem [0:1023];

   // Contents are undefined after reset, as in any plain RAM
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule

`default_nettype wire

// >>> conv_meas_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural analog engine: returns a word that names channel and type
module conv_meas_model (
   // Clock
   input wire logic clk_sys,
   // Request from the controller
   input wire conv_ctrl_pkg::meas_req_t meas,
   // Result back to the controller
   output logic [31:0] result_word
);
   logic [31:0] word_r = 32'h0000_0000;

   // Latch a result per request so a mixed-up channel shows in the slot
   always @(posedge clk_sys) begin
      if (meas.start) begin
         word_r <= {8'h01, 11'h000, meas.sensor, 4'h0, meas.channel};
      end
   end
   assign result_word = word_r;
endmodule

`default_nettype wire

// >>> test_conversion_command_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_conversion_command_control;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   conv_ctrl_pkg::host_req_t host = '0;
   logic [7:0] rdata;
   conv_ctrl_pkg::meas_req_t meas;
   logic [31:0] result_word;
   logic done_pin, sleep, irq;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int starts = 0;
   logic [3:0] seen_ch[$];
   conv_ctrl_pkg::sensor_class_t last_class;
   logic last_paired;
   logic nvm_start, done_pin_nvm;
   logic [4:0] nvm_code;
   logic nvm_done = 1'b0;

   conv_ctrl #(.CYCLE_CLKS(8), .HAS_NVM(1'b0)) DUT (
      .clk_sys(clk_sys), .reset(reset), .host(host), .rdata(rdata),
      .meas(meas), .result_word(result_word),
      .nvm_start(), .nvm_code(), .nvm_done(1'b0),
      .done_pin(done_pin), .sleep(sleep), .irq(irq));

   conv_meas_model partner (.clk_sys(clk_sys), .meas(meas), .result_word(result_word));

   // Storage variant shares the host bus; only its storage path is judged
   conv_ctrl #(.CYCLE_CLKS(8), .HAS_NVM(1'b1)) DUT_NVM (
      .clk_sys(clk_sys), .reset(reset), .host(host), .rdata(),
      .meas(), .result_word(result_word),
      .nvm_start(nvm_start), .nvm_code(nvm_code), .nvm_done(nvm_done),
      .done_pin(done_pin_nvm), .sleep(), .irq());

   ////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and request log
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (meas.start === 1'b1) begin
         starts++;
         seen_ch.push_back(meas.channel);
         last_class = meas.sclass;
         last_paired = meas.paired;
      end
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Strobes are launched and dropped right after an edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      host <= '0;
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      host <= '0;
      #1 chk(rdata, exp);
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
   endtask

   // Waits for the completion pin to rise after having gone low
   task automatic wait_done(output int n);
      n = 0;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk_sys);
         #1;
         if (done_pin === 1'b0) n++;
         else if (n > 0) break;
      end
   endtask

   function automatic conv_ctrl_pkg::sensor_class_t cls(input int t);
      if (t == 0) return conv_ctrl_pkg::SC_DISABLED;
      if (t <= 8) return conv_ctrl_pkg::SC_TC_STD;
      if (t == 9) return conv_ctrl_pkg::SC_TC_CUSTOM;
      if (t <= 17) return conv_ctrl_pkg::SC_RTD_STD;
      if (t == 18) return conv_ctrl_pkg::SC_RTD_CUSTOM;
      if (t <= 25) return conv_ctrl_pkg::SC_THERM_FIXED;
      if (t == 26) return conv_ctrl_pkg::SC_THERM_SH;
      if (t == 27) return conv_ctrl_pkg::SC_THERM_TABLE;
      if (t == 28) return conv_ctrl_pkg::SC_DIODE;
      if (t == 29) return conv_ctrl_pkg::SC_SENSE_RES;
      if (t == 30) return conv_ctrl_pkg::SC_DIRECT_ADC;
      return conv_ctrl_pkg::SC_ANALOG_TS;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_reset_values();
      int s;
      #1 chk(done_pin, 1'b1);
      chk(irq, 1'b0);
      rd_chk(10'h000, 8'h00);
      rd_chk(10'h0f0, 8'h00);
      // An unassigned channel after reset converts nothing
      s = starts;
      wr(10'h000, 8'h81);
      repeat (3) @(posedge clk_sys);
      #1 chk(starts, s);
      chk(done_pin, 1'b1);
      rd_chk(10'h000, 8'h41);
      $display("test reset values done");
   endtask

   task automatic test_single_lockout();
      int n;
      wr(10'h0f4, 8'h07);
      wr(10'h200, 8'h08);
      wr(10'h000, 8'h81);
      @(posedge clk_sys);
      #1 chk(done_pin, 1'b0);
      rd_chk(10'h000, 8'h81);
      rd_chk(10'h200, 8'h00);
      wr(10'h200, 8'hf8);
      wait_done(n);
      rd_chk(10'h000, 8'h41);
      rd_chk(10'h200, 8'h08);
      rd_chk(10'h010, 8'h01);
      rd_chk(10'h011, 8'h00);
      rd_chk(10'h012, 8'h01);
      rd_chk(10'h013, 8'h01);
      chk(irq, 1'b1);
      rd_chk(10'h0f0, 8'h03);
      wr(10'h0f0, 8'h03);
      @(posedge clk_sys);
      #1 chk(irq, 1'b0);
      $display("test single channel and lockout done");
   endtask

   // Every nonzero type code on channel 3, with its pass count
   task automatic test_type_codes();
      int n;
      int p;
      for (int t = 1; t < 32; t++) begin
         p = (t <= 27) ? 3 : 2;
         wr(10'h208, 8'(t << 3));
         seen_ch.delete();
         wr(10'h000, 8'h83);
         wait_done(n);
         chk(last_class, cls(t));
         chk(seen_ch.size(), 1);
         chk(last_paired, p == 3);
         chk((n >= 8 * p + 2) && (n <= 8 * p + 7), 1'b1);
         rd_chk(10'h01a, 8'(t));
      end
      $display("test type codes done");
   endtask

   task automatic test_multi_scan();
      int n;
      do_reset();
      wr(10'h204, 8'h28);
      wr(10'h210, 8'hf0);
      seen_ch.delete();
      wr(10'h000, 8'h80);
      wait_done(n);
      chk(seen_ch.size(), 2);
      chk(seen_ch[0], 4'h2);
      chk(seen_ch[1], 4'h5);
      rd_chk(10'h000, 8'h40);
      rd_chk(10'h020, 8'h01);
      rd_chk(10'h022, 8'h1e);
      rd_chk(10'h023, 8'h05);
      $display("test multi channel scan done");
   endtask

   task automatic test_sleep_reserved();
      int s;
      wr(10'h000, 8'h97);
      repeat (3) @(posedge clk_sys);
      #1 chk(sleep, 1'b1);
      chk(done_pin, 1'b1);
      wr(10'h000, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 chk(sleep, 1'b0);
      wr(10'h0f4, 8'h00);
      wr(10'h0f0, 8'h07);
      s = starts;
      wr(10'h000, 8'h8b);
      repeat (4) @(posedge clk_sys);
      #1 chk(done_pin, 1'b1);
      chk(starts, s);
      chk(irq, 1'b0);
      // The storage variant takes the same code as a storage operation
      chk(nvm_start, 1'b1);
      chk(nvm_code, 5'h0b);
      chk(done_pin_nvm, 1'b0);
      @(posedge clk_sys);
      nvm_done <= 1'b1;
      @(posedge clk_sys);
      nvm_done <= 1'b0;
      #1 chk(done_pin_nvm, 1'b1);
      chk(nvm_start, 1'b0);
      rd_chk(10'h0f0, 8'h04);
      wr(10'h0f4, 8'h04);
      @(posedge clk_sys);
      #1 chk(irq, 1'b1);
      wr(10'h000, 8'h8a);
      repeat (6) @(posedge clk_sys);
      rd_chk(10'h000, 8'h4a);
      chk(starts, s);
      $display("test sleep, reserved and idle channel done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      test_reset_values();
      test_single_lockout();
      test_type_codes();
      test_multi_scan();
      test_sleep_reserved();
      tally_and_finish();
   end
endmodule

`default_nettype wire
